// ### common/tsm_map.svh
`ifndef TSM_MAP_SVH
`define TSM_MAP_SVH
// Register addresses on the serial port
`define TSM_ADDR_OP_MODE 7'h01
`define TSM_ADDR_BR_HIGH 7'h02
`define TSM_ADDR_BR_LOW 7'h03
`define TSM_ADDR_FDEV_HIGH 7'h04
`define TSM_ADDR_FDEV_LOW 7'h05
`define TSM_ADDR_FRF_HIGH 7'h06
`define TSM_ADDR_FRF_MID 7'h07
`define TSM_ADDR_FRF_LOW 7'h08
`define TSM_ADDR_OSC 7'h0A
`define TSM_ADDR_PA_RAMP 7'h0B
`define TSM_ADDR_PLL 7'h0C
`define TSM_ADDR_PIN_MAP_B 7'h41
`define TSM_ADDR_BR_FRAC 7'h5D
// Reset values
`define TSM_RST_OP_MODE 8'h01
`define TSM_RST_BR 16'h1A0B
`define TSM_RST_FDEV 14'h0052
`define TSM_RST_FRF 24'hE4C000
`define TSM_RST_PA_RAMP 8'h09
`define TSM_RST_PLL 8'h00
`define TSM_RST_CLK_SEL 3'h0
// Field positions
`define TSM_F_MODE 2:0
`define TSM_F_OOK 5
`define TSM_F_CONT 6
`define TSM_F_CAL_START 3
`define TSM_F_CAL_DONE 1
`define TSM_F_SHAPING 6:5
`define TSM_F_PLL_LOW_NOISE 2
`define TSM_F_PLL_BW 1:0
`define TSM_F_CLK_SEL 2:0
`define TSM_F_FRAC 3:0
// Serial frame and timing counts
`define TSM_SPI_ADDR_LAST 5'd7
`define TSM_SPI_MISO_FIRST 5'd9
`define TSM_SPI_LAST 5'd15
`define TSM_SPI_LAST_STEP 6'd32
`define TSM_PHASE_STEP 21'h000010
`define TSM_CLK_SEL_MAX 3'h5
`define TSM_BIAS_MAX 6'h3F
`endif

// ### common/tsm_pkg.sv
package tsm_pkg;
   typedef enum logic [2:0] {
      TSM_SLEEP = 3'h0,
      TSM_STANDBY = 3'h1,
      TSM_FS_TX = 3'h2,
      TSM_TX = 3'h3,
      TSM_FS_RX = 3'h4,
      TSM_RX = 3'h5,
      TSM_RSVD6 = 3'h6,
      TSM_RSVD7 = 3'h7
   } tsm_mode_t;
   typedef enum logic [1:0] {
      TSM_SHAPE_NONE = 2'h0,
      TSM_SHAPE_BT1 = 2'h1,
      TSM_SHAPE_BT05 = 2'h2,
      TSM_SHAPE_RSVD = 2'h3
   } tsm_shape_t;
   typedef enum {
      TSM_H_IDLE,
      TSM_H_XFER,
      TSM_H_GAP
   } tsm_host_state_t;
endpackage : tsm_pkg

// ### common/tsm_link_if.sv
`timescale 1ns/1ps
interface tsm_link_if (
   input wire logic link_clk
);
   logic sck;
   logic nss_n;
   logic mosi;
   logic miso;
   logic data_pin;
   logic bit_clk;
   logic clk_out;
   modport dev (
      input link_clk, sck, nss_n, mosi, data_pin,
      output miso, bit_clk, clk_out
   );
   modport host (
      input miso, bit_clk, clk_out,
      output sck, nss_n, mosi, data_pin
   );
endinterface : tsm_link_if

// ### design/tsm_dev_end.sv
`timescale 1ns/1ps
`include "tsm_map.svh"
// Contract
// - Frequency step is reference over 2^19
// - Carrier is step times 24-bit word
// - Carrier applied only on low byte write
// - Reference clock divided out on pin five
// - Clock out on at reset, off in sleep
// - Two transmit PLLs, four bandwidths each
// - Receive forces low consumption PLL
// - RC calibration runs automatically after reset
// - Requested recalibration sets done flag
// - Data direct, or synced by bit clock; the bit clock runs only for FSK with Gaussian shaping on
// - Bit rate divisor plus fraction/16
// - OOK ignores fractional bit rate
// - Deviation is step times 14-bit field
// - Host keeps deviation within limits
// - OOK keys amplifier with data bit
// - Gaussian BT 0.5 or 1 before modulator
// - Bit clock pulses; host supplies next bit
// - OOK shaping ramps amplifier bias gradually
// - Host restarts transmitter after shaping change
module tsm_dev_end #(
   parameter int CAL_CYCLES = 256
) (
   // Link pins, clocked by the link clock
   tsm_link_if.dev link,
   // Reset
   input wire logic rst_n_in,
   // Synthesizer and modulator controls
   output logic [23:0] carrier_word_out,
   output logic [23:0] synth_word_out,
   output logic pll_low_noise_out,
   output logic [1:0] pll_bw_out,
   output logic pa_on_out,
   output logic [5:0] pa_bias_out,
   output logic rc_cal_busy_out,
   output tsm_pkg::tsm_mode_t mode_out
);
   logic clk;
   logic [3:0] s1_r;
   logic [3:0] s2_r;
   logic sck_d_r;
   logic sck_rise;
   logic sck_fall;
   logic nss;
   logic mosi;
   logic din;
   logic [4:0] bit_cnt_r;
   logic [15:0] shift_r;
   logic [15:0] word_nxt;
   logic [7:0] miso_r;
   logic [6:0] rd_addr;
   logic [7:0] rd_data;
   logic wr_en;
   logic [6:0] wr_addr;
   logic [7:0] wr_data;
   logic [7:0] op_mode_r;
   logic [15:0] br_r;
   logic [3:0] frac_r;
   logic [13:0] fdev_r;
   logic [7:0] frf_hi_r;
   logic [7:0] frf_mid_r;
   logic [23:0] carrier_r;
   logic [7:0] pa_ramp_r;
   logic [7:0] pll_r;
   logic [2:0] clk_sel_r;
   logic cal_busy_r;
   logic cal_done_r;
   logic [31:0] cal_cnt_r;
   logic cal_req;
   logic cal_end;
   tsm_pkg::tsm_mode_t mode;
   tsm_pkg::tsm_shape_t shape;
   logic ook;
   logic tx_run;
   logic gauss_on;
   logic [19:0] period;
   logic [20:0] phase_r;
   logic [20:0] phase_step;
   logic [20:0] phase_new;
   logic bclk_r;
   logic bclk_nxt;
   logic [3:0] taps_r;
   logic cur_bit;
   logic [2:0] ones;
   logic [16:0] prod;
   logic signed [17:0] dev_s;
   logic [5:0] div_cnt_r;
   logic clk_out_r;

   assign clk = link.link_clk;

   // Pin synchronisers: sck, nss_n, mosi, data
   always_ff @(posedge clk or negedge rst_n_in) begin
      if (!rst_n_in) begin
         s1_r <= 4'h2;
         s2_r <= 4'h2;
         sck_d_r <= 1'b0;
      end else begin
         s1_r <= {link.data_pin, link.mosi, link.nss_n, link.sck};
         s2_r <= s1_r;
         sck_d_r <= s2_r[0];
      end
   end
   assign sck_rise = s2_r[0] & ~sck_d_r;
   assign sck_fall = ~s2_r[0] & sck_d_r;
   assign nss = s2_r[1];
   assign mosi = s2_r[2];
   assign din = s2_r[3];

   // Serial slave: write flag, 7-bit address, one data byte
   assign word_nxt = {shift_r[14:0], mosi};
   assign rd_addr = word_nxt[6:0];
   assign wr_addr = word_nxt[14:8];
   assign wr_data = word_nxt[7:0];
   assign wr_en = sck_rise & ~nss & (bit_cnt_r == `TSM_SPI_LAST)
      & word_nxt[15];

   always_ff @(posedge clk or negedge rst_n_in) begin
      if (!rst_n_in) begin
         bit_cnt_r <= 5'h00;
         shift_r <= 16'h0000;
         miso_r <= 8'h00;
      end else if (nss) begin
         bit_cnt_r <= 5'h00;
         miso_r <= 8'h00;
      end else if (sck_rise) begin
         bit_cnt_r <= bit_cnt_r + 5'h01;
         shift_r <= word_nxt;
         if (bit_cnt_r == `TSM_SPI_ADDR_LAST) begin
            miso_r <= rd_data;
         end
      end else if (sck_fall && bit_cnt_r >= `TSM_SPI_MISO_FIRST) begin
         miso_r <= {miso_r[6:0], 1'b0};
      end
   end

   always_comb begin
      case (rd_addr)
         `TSM_ADDR_OP_MODE: rd_data = op_mode_r;
         `TSM_ADDR_BR_HIGH: rd_data = br_r[15:8];
         `TSM_ADDR_BR_LOW: rd_data = br_r[7:0];
         `TSM_ADDR_FDEV_HIGH: rd_data = {2'b00, fdev_r[13:8]};
         `TSM_ADDR_FDEV_LOW: rd_data = fdev_r[7:0];
         `TSM_ADDR_FRF_HIGH: rd_data = frf_hi_r;
         `TSM_ADDR_FRF_MID: rd_data = frf_mid_r;
         `TSM_ADDR_FRF_LOW: rd_data = carrier_r[7:0];
         `TSM_ADDR_OSC: rd_data = {6'h00, cal_done_r, 1'b0};
         `TSM_ADDR_PA_RAMP: rd_data = pa_ramp_r;
         `TSM_ADDR_PLL: rd_data = pll_r;
         `TSM_ADDR_PIN_MAP_B: rd_data = {5'h00, clk_sel_r};
         `TSM_ADDR_BR_FRAC: rd_data = {4'h0, frac_r};
         default: rd_data = 8'h00;
      endcase
   end

   // Register file
   always_ff @(posedge clk or negedge rst_n_in) begin
      if (!rst_n_in) begin
         op_mode_r <= `TSM_RST_OP_MODE;
         br_r <= `TSM_RST_BR;
         frac_r <= 4'h0;
         fdev_r <= `TSM_RST_FDEV;
         frf_hi_r <= 8'(`TSM_RST_FRF >> 16);
         frf_mid_r <= 8'(`TSM_RST_FRF >> 8);
         carrier_r <= `TSM_RST_FRF;
         pa_ramp_r <= `TSM_RST_PA_RAMP;
         pll_r <= `TSM_RST_PLL;
         clk_sel_r <= `TSM_RST_CLK_SEL;
      end else if (wr_en) begin
         case (wr_addr)
            `TSM_ADDR_OP_MODE: op_mode_r <= wr_data;
            `TSM_ADDR_BR_HIGH: br_r[15:8] <= wr_data;
            `TSM_ADDR_BR_LOW: br_r[7:0] <= wr_data;
            `TSM_ADDR_FDEV_HIGH: fdev_r[13:8] <= wr_data[5:0];
            `TSM_ADDR_FDEV_LOW: fdev_r[7:0] <= wr_data;
            `TSM_ADDR_FRF_HIGH: frf_hi_r <= wr_data;
            `TSM_ADDR_FRF_MID: frf_mid_r <= wr_data;
            `TSM_ADDR_FRF_LOW: carrier_r <= {frf_hi_r, frf_mid_r, wr_data};
            `TSM_ADDR_PA_RAMP: pa_ramp_r <= wr_data;
            `TSM_ADDR_PLL: pll_r <= wr_data;
            `TSM_ADDR_PIN_MAP_B: clk_sel_r <= wr_data[`TSM_F_CLK_SEL];
            `TSM_ADDR_BR_FRAC: frac_r <= wr_data[`TSM_F_FRAC];
            default: ;
         endcase
      end
   end

   // RC calibration: starts out of reset, restarts on request
   assign cal_req = wr_en & (wr_addr == `TSM_ADDR_OSC)
      & wr_data[`TSM_F_CAL_START];
   assign cal_end = cal_busy_r & (cal_cnt_r == 32'(CAL_CYCLES - 1));
   always_ff @(posedge clk or negedge rst_n_in) begin
      if (!rst_n_in) begin
         cal_busy_r <= 1'b1;
         cal_done_r <= 1'b0;
         cal_cnt_r <= 32'h00000000;
      end else begin
         if (cal_req) begin
            cal_busy_r <= 1'b1;
            cal_cnt_r <= 32'h00000000;
         end else if (cal_end) begin
            cal_busy_r <= 1'b0;
         end else if (cal_busy_r) begin
            cal_cnt_r <= cal_cnt_r + 32'h00000001;
         end
         // Completion in the same cycle as a new request still sets done
         if (cal_end) begin
            cal_done_r <= 1'b1;
         end else if (cal_req) begin
            cal_done_r <= 1'b0;
         end
      end
   end

   // Bit rate: phase advances 16 per cycle against divisor*16+frac
   assign mode = tsm_pkg::tsm_mode_t'(op_mode_r[`TSM_F_MODE]);
   assign shape = tsm_pkg::tsm_shape_t'(pa_ramp_r[`TSM_F_SHAPING]);
   assign ook = op_mode_r[`TSM_F_OOK];
   assign tx_run = (mode == tsm_pkg::TSM_TX);
   assign gauss_on = ~ook & op_mode_r[`TSM_F_CONT]
      & (shape != tsm_pkg::TSM_SHAPE_NONE);
   assign period = {br_r, 4'h0} + {16'h0000, ook ? 4'h0 : frac_r};
   assign phase_step = phase_r + `TSM_PHASE_STEP;
   assign phase_new = (phase_step >= {1'b0, period}) ?
      phase_step - {1'b0, period} : phase_step;
   assign bclk_nxt = tx_run & gauss_on
      & (phase_new < {2'b00, period[19:1]});

   always_ff @(posedge clk or negedge rst_n_in) begin
      if (!rst_n_in) begin
         phase_r <= 21'h000000;
         bclk_r <= 1'b0;
         taps_r <= 4'h0;
      end else begin
         phase_r <= tx_run ? phase_new : 21'h000000;
         bclk_r <= bclk_nxt;
         // Bit taken at mid-bit, half a period after the request edge
         if (bclk_r && !bclk_nxt) begin
            taps_r <= {taps_r[2:0], din};
         end
      end
   end

   // Modulation: direct pin data or filtered stream
   assign cur_bit = gauss_on ? taps_r[0] : din;
   always_comb begin
      ones = 3'h0;
      prod = 17'h00000;
      dev_s = 18'sh00000;
      unique case (shape)
         tsm_pkg::TSM_SHAPE_BT1: begin
            ones = {2'b00, taps_r[0]} + {2'b00, taps_r[1]};
            prod = {3'b000, fdev_r} * {14'h0000, ones};
            dev_s = $signed({1'b0, prod}) - $signed({4'h0, fdev_r});
         end
         tsm_pkg::TSM_SHAPE_BT05: begin
            ones = {2'b00, taps_r[0]} + {2'b00, taps_r[1]}
               + {2'b00, taps_r[2]} + {2'b00, taps_r[3]};
            prod = {3'b000, fdev_r} * {14'h0000, ones};
            dev_s = $signed({2'b00, prod[16:1]})
               - $signed({4'h0, fdev_r});
         end
         default: begin
            dev_s = cur_bit ? $signed({4'h0, fdev_r})
               : -$signed({4'h0, fdev_r});
         end
      endcase
   end

   // Synthesizer word in frequency steps of reference/2^19
   always_ff @(posedge clk or negedge rst_n_in) begin
      if (!rst_n_in) begin
         synth_word_out <= `TSM_RST_FRF;
         carrier_word_out <= `TSM_RST_FRF;
         pll_low_noise_out <= 1'b0;
         pll_bw_out <= 2'h0;
         pa_on_out <= 1'b0;
         mode_out <= tsm_pkg::TSM_STANDBY;
         rc_cal_busy_out <= 1'b1;
      end else begin
         carrier_word_out <= carrier_r;
         synth_word_out <= (tx_run && !ook) ?
            carrier_r + 24'(dev_s) : carrier_r;
         pll_low_noise_out <= (mode == tsm_pkg::TSM_RX
            || mode == tsm_pkg::TSM_FS_RX) ? 1'b0
            : pll_r[`TSM_F_PLL_LOW_NOISE];
         pll_bw_out <= pll_r[`TSM_F_PLL_BW];
         pa_on_out <= tx_run & (~ook | cur_bit);
         mode_out <= mode;
         rc_cal_busy_out <= cal_busy_r;
      end
   end

   // Amplifier bias: ramps one step per cycle when OOK shaping is on
   always_ff @(posedge clk or negedge rst_n_in) begin
      if (!rst_n_in) begin
         pa_bias_out <= 6'h00;
      end else if (ook && shape != tsm_pkg::TSM_SHAPE_NONE) begin
         if (pa_on_out && pa_bias_out != `TSM_BIAS_MAX) begin
            pa_bias_out <= pa_bias_out + 6'h01;
         end else if (!pa_on_out && pa_bias_out != 6'h00) begin
            pa_bias_out <= pa_bias_out - 6'h01;
         end
      end else begin
         pa_bias_out <= pa_on_out ? `TSM_BIAS_MAX : 6'h00;
      end
   end

   // Reference clock out: divide by 2^(sel+1), off in sleep
   always_ff @(posedge clk or negedge rst_n_in) begin
      if (!rst_n_in) begin
         div_cnt_r <= 6'h00;
         clk_out_r <= 1'b0;
      end else begin
         div_cnt_r <= div_cnt_r + 6'h01;
         clk_out_r <= (mode != tsm_pkg::TSM_SLEEP)
            && (clk_sel_r <= `TSM_CLK_SEL_MAX)
            && div_cnt_r[clk_sel_r];
      end
   end

   assign link.miso = miso_r[7];
   assign link.bit_clk = bclk_r;
   assign link.clk_out = clk_out_r;
endmodule : tsm_dev_end

// ### design/tsm_host_end.sv
`timescale 1ns/1ps
`include "tsm_map.svh"
module tsm_host_end #(
   parameter int SCK_HALF = 20
) (
   // Link pins
   tsm_link_if.host link,
   // Clock and reset
   input wire logic ref_clk_in,
   input wire logic rst_n_in,
   // Register access requests
   input wire logic req_valid_in,
   input wire logic req_write_in,
   input wire logic [6:0] req_addr_in,
   input wire logic [7:0] req_wdata_in,
   output logic req_ready_out,
   output logic rsp_valid_out,
   output logic [7:0] rsp_rdata_out,
   // Transmit data
   input wire logic tx_sync_mode_in,
   input wire logic tx_bit_in,
   output logic tx_bit_take_out,
   // Reference clock seen from the device
   output logic ref_clk_level_out
);
   tsm_pkg::tsm_host_state_t state_r;
   logic [2:0] s1_r;
   logic [2:0] s2_r;
   logic bclk_d_r;
   logic [31:0] half_cnt_r;
   logic tick;
   logic [5:0] step_r;
   logic sck_r;
   logic nss_n_r;
   logic [15:0] tx_r;
   logic [7:0] rx_r;
   logic data_r;

   // Synchronisers: miso, bit clock, clock out
   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         s1_r <= 3'h0;
         s2_r <= 3'h0;
         bclk_d_r <= 1'b0;
      end else begin
         s1_r <= {link.clk_out, link.bit_clk, link.miso};
         s2_r <= s1_r;
         bclk_d_r <= s2_r[1];
      end
   end

   assign tick = (half_cnt_r == 32'(SCK_HALF - 1));
   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         half_cnt_r <= 32'h00000000;
      end else if (state_r == tsm_pkg::TSM_H_IDLE || tick) begin
         half_cnt_r <= 32'h00000000;
      end else begin
         half_cnt_r <= half_cnt_r + 32'h00000001;
      end
   end

   // Serial master: one 16-bit frame per request
   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         state_r <= tsm_pkg::TSM_H_IDLE;
         step_r <= 6'h00;
         sck_r <= 1'b0;
         nss_n_r <= 1'b1;
         tx_r <= 16'h0000;
         rx_r <= 8'h00;
         rsp_valid_out <= 1'b0;
         rsp_rdata_out <= 8'h00;
      end else begin
         rsp_valid_out <= 1'b0;
         unique case (state_r)
            tsm_pkg::TSM_H_IDLE: begin
               if (req_valid_in) begin
                  state_r <= tsm_pkg::TSM_H_XFER;
                  step_r <= 6'h00;
                  nss_n_r <= 1'b0;
                  tx_r <= {req_write_in, req_addr_in, req_wdata_in};
               end
            end
            tsm_pkg::TSM_H_XFER: begin
               if (tick) begin
                  if (step_r == `TSM_SPI_LAST_STEP) begin
                     state_r <= tsm_pkg::TSM_H_GAP;
                     nss_n_r <= 1'b1;
                     rsp_valid_out <= 1'b1;
                     rsp_rdata_out <= rx_r;
                  end else begin
                     step_r <= step_r + 6'h01;
                     sck_r <= ~sck_r;
                     if (!sck_r) begin
                        rx_r <= {rx_r[6:0], s2_r[0]};
                     end else begin
                        tx_r <= {tx_r[14:0], 1'b0};
                     end
                  end
               end
            end
            tsm_pkg::TSM_H_GAP: begin
               if (tick) begin
                  state_r <= tsm_pkg::TSM_H_IDLE;
               end
            end
         endcase
      end
   end
   assign req_ready_out = (state_r == tsm_pkg::TSM_H_IDLE);

   // Transmit data: follows input, or steps on each bit clock rise
   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         data_r <= 1'b0;
         tx_bit_take_out <= 1'b0;
         ref_clk_level_out <= 1'b0;
      end else begin
         tx_bit_take_out <= 1'b0;
         ref_clk_level_out <= s2_r[2];
         if (!tx_sync_mode_in) begin
            data_r <= tx_bit_in;
         end else if (s2_r[1] && !bclk_d_r) begin
            data_r <= tx_bit_in;
            tx_bit_take_out <= 1'b1;
         end
      end
   end

   assign link.sck = sck_r;
   assign link.nss_n = nss_n_r;
   assign link.mosi = tx_r[15];
   assign link.data_pin = data_r;
endmodule : tsm_host_end

// ### verification/tsm_link_asserts.sv
`timescale 1ns/1ps
module tsm_link_asserts (
   // Link clock and reset
   input wire logic link_clk,
   input wire logic rst_n_in,
   // Link signals
   input wire logic sck,
   input wire logic nss_n,
   input wire logic mosi,
   input wire logic miso,
   input wire logic data_pin,
   input wire logic bit_clk,
   input wire logic clk_out
);
   default clocking cb @(posedge link_clk);
   endclocking
   default disable iff (!rst_n_in);

   clk_on_reset_a:
      assert property ($rose(rst_n_in) |-> ##[1:6] $changed(clk_out) [*4])
      else $error("Reference clock output not running after reset");
   sck_idle_a:
      assert property (nss_n |-> !sck)
      else $error("Serial clock moves while deselected");
   miso_idle_a:
      assert property (nss_n [*4] |-> !miso)
      else $error("Read line driven while deselected");
   frame_len_a:
      assert property ($fell(nss_n) |-> ##[165:176] $rose(nss_n))
      else $error("Serial frame length wrong");
   frame_gap_a:
      assert property ($rose(nss_n) |-> nss_n [*5])
      else $error("Select gap between frames too short");
   first_edge_a:
      assert property ($fell(nss_n) |-> !sck [*3] ##[1:6] $rose(sck))
      else $error("First serial clock edge misplaced");
   data_hold_a:
      assert property ($fell(bit_clk) |-> data_pin == $past(data_pin, 3))
      else $error("Data pin moved near bit clock fall");
   bit_low_a:
      assert property ($fell(bit_clk) |-> !bit_clk [*3])
      else $error("Bit clock low phase too short");
endmodule : tsm_link_asserts

// ### verification/tsm_bench.sv
`timescale 1ns/1ps
module tsm_bench;
   logic ref_clk_in, link_clk, rst_n_in, tx_sync_mode_in, tx_bit_in;
   logic req_valid_in, req_write_in, req_ready_out, rsp_valid_out;
   logic [6:0] req_addr_in;
   logic [7:0] req_wdata_in, rsp_rdata_out, rd;
   logic tx_bit_take_out, ref_clk_level_out, pll_low_noise_out;
   logic pa_on_out, rc_cal_busy_out;
   logic [23:0] carrier_word_out, synth_word_out;
   logic [1:0] pll_bw_out;
   logic [5:0] pa_bias_out, b0;
   tsm_pkg::tsm_mode_t mode_out;
   int mismatches, n_checks, n;
   localparam logic [6:0] RA [13] = '{7'h01, 7'h02, 7'h03, 7'h04, 7'h05,
      7'h06, 7'h07, 7'h08, 7'h0B, 7'h0C, 7'h41, 7'h5D, 7'h30};
   localparam logic [7:0] RV [13] = '{8'h01, 8'h1A, 8'h0B, 8'h00, 8'h52,
      8'hE4, 8'hC0, 8'h00, 8'h09, 8'h00, 8'h00, 8'h00, 8'h00};
   localparam logic [7:0] RM [13] = '{8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF,
      8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h07, 8'h0F, 8'hFF};

   tsm_link_if link_if (.link_clk(link_clk));
   tsm_dev_end #(.CAL_CYCLES(64)) i_tsm_dev_end (.link(link_if.dev),
      .rst_n_in(rst_n_in), .carrier_word_out(carrier_word_out),
      .synth_word_out(synth_word_out), .pll_low_noise_out(pll_low_noise_out),
      .pll_bw_out(pll_bw_out), .pa_on_out(pa_on_out),
      .pa_bias_out(pa_bias_out), .rc_cal_busy_out(rc_cal_busy_out),
      .mode_out(mode_out));
   tsm_host_end i_tsm_host_end (.link(link_if.host), .ref_clk_in(ref_clk_in),
      .rst_n_in(rst_n_in), .req_valid_in(req_valid_in),
      .req_write_in(req_write_in), .req_addr_in(req_addr_in),
      .req_wdata_in(req_wdata_in), .req_ready_out(req_ready_out),
      .rsp_valid_out(rsp_valid_out), .rsp_rdata_out(rsp_rdata_out),
      .tx_sync_mode_in(tx_sync_mode_in), .tx_bit_in(tx_bit_in),
      .tx_bit_take_out(tx_bit_take_out),
      .ref_clk_level_out(ref_clk_level_out));
   tsm_link_asserts u_asserts (.link_clk(link_clk), .rst_n_in(rst_n_in),
      .sck(link_if.sck), .nss_n(link_if.nss_n), .mosi(link_if.mosi),
      .miso(link_if.miso), .data_pin(link_if.data_pin),
      .bit_clk(link_if.bit_clk), .clk_out(link_if.clk_out));

   initial begin
      ref_clk_in = 1'b0;
      forever #4 ref_clk_in = ~ref_clk_in;
   end
   initial begin
      link_clk = 1'b0;
      #7.3;
      forever #15 link_clk = ~link_clk;
   end

   task automatic end_sim;
      $display("Checks %0d, mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : end_sim

   task automatic chk(input logic [23:0] got, input logic [23:0] exp);
      n_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("Error at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic fail_wait;
      mismatches++;
      $display("Error at %0t: wait ran out, got %h, expected %h", $time,
         1'b0, 1'b1);
      end_sim();
   endtask : fail_wait

   task automatic access(input logic w, input logic [6:0] a,
         input logic [7:0] d);
      int k;
      @(posedge ref_clk_in);
      #1;
      req_valid_in = 1'b1;
      req_write_in = w;
      req_addr_in = a;
      req_wdata_in = d;
      for (k = 0; req_ready_out !== 1'b1; k++) begin
         if (k > 1000) fail_wait();
         @(posedge ref_clk_in);
         #1;
      end
      @(posedge ref_clk_in);
      #1;
      req_valid_in = 1'b0;
      for (k = 0; rsp_valid_out !== 1'b1; k++) begin
         if (k > 1000) fail_wait();
         @(posedge ref_clk_in);
         #1;
      end
      rd = rsp_rdata_out;
      // The link side applies a write on the last serial clock rise, before the frame ends
      repeat (8) @(posedge ref_clk_in);
      #1;
   endtask : access

   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      access(1'b1, a, d);
   endtask : wr

   task automatic rd_chk(input logic [6:0] a, input logic [7:0] e,
         input logic [7:0] m);
      access(1'b0, a, 8'h00);
      chk(24'(rd & m), 24'(e));
   endtask : rd_chk

   task automatic wait_sig(input bit pa, input logic v);
      int k;
      for (k = 0; (pa ? pa_on_out : rc_cal_busy_out) !== v; k++) begin
         if (k > 300) fail_wait();
         @(posedge link_clk);
         #1;
      end
   endtask : wait_sig

   // Cycles over nr periods, skipping the first period seen
   task automatic span(input bit bc, input int nr, output int len);
      int k, r;
      logic p, c;
      r = 0;
      len = 0;
      p = 1'b1;
      for (k = 0; r <= nr + 1; k++) begin
         if (k > 3000) fail_wait();
         @(posedge link_clk);
         #1;
         c = bc ? link_if.bit_clk : link_if.clk_out;
         if (r > 1) len++;
         if (c === 1'b1 && p === 1'b0) r++;
         p = c;
      end
   endtask : span

   task automatic quiet(output int c);
      logic p;
      c = 0;
      p = link_if.clk_out;
      repeat (100) begin
         @(posedge link_clk);
         #1;
         if (link_if.clk_out !== p) c++;
         p = link_if.clk_out;
      end
   endtask : quiet

   task automatic takes(input logic b, input int cnt);
      int k, t;
      tx_bit_in = b;
      t = 0;
      for (k = 0; t < cnt; k++) begin
         if (k > 5000) fail_wait();
         @(posedge ref_clk_in);
         #1;
         if (tx_bit_take_out === 1'b1) t++;
      end
   endtask : takes

   initial begin
      {req_valid_in, req_write_in, tx_sync_mode_in, tx_bit_in} = 4'h0;
      req_addr_in = 7'h00;
      req_wdata_in = 8'h00;
      mismatches = 0;
      n_checks = 0;
      rst_n_in = 1'b0;
      repeat (8) @(posedge ref_clk_in);
      #1;
      rst_n_in = 1'b1;
      chk(carrier_word_out, 24'hE4C000);
      wait_sig(1'b0, 1'b0);
      rd_chk(7'h0A, 8'h02, 8'h02);
      foreach (RA[i]) begin
         rd_chk(RA[i], RV[i], RM[i]);
      end
      $display("Reset values done");
      wr(7'h06, 8'hD9);
      wr(7'h07, 8'h20);
      chk(carrier_word_out, 24'hE4C000);
      rd_chk(7'h07, 8'h20, 8'hFF);
      wr(7'h08, 8'h40);
      chk(carrier_word_out, 24'hD92040);
      wr(7'h0A, 8'h08);
      chk(24'(rc_cal_busy_out), 24'h000001);
      wait_sig(1'b0, 1'b0);
      rd_chk(7'h0A, 8'h02, 8'h02);
      $display("Carrier and calibration done");
      for (int s = 0; s < 8; s++) begin
         wr(7'h41, 8'(s));
         if (s < 6) begin
            span(1'b0, 1, n);
            chk(24'(n), 24'(2 << s));
         end else begin
            quiet(n);
            chk(24'(n), 24'h000000);
         end
      end
      wr(7'h41, 8'h00);
      wr(7'h01, 8'h00);
      quiet(n);
      chk(24'(n), 24'h000000);
      chk(24'(ref_clk_level_out), 24'h000000);
      wr(7'h01, 8'h01);
      span(1'b0, 1, n);
      chk(24'(n), 24'h000002);
      $display("Clock output done");
      for (int b = 0; b < 4; b++) begin
         wr(7'h0C, 8'h04 | 8'(b));
         chk(24'({pll_low_noise_out, pll_bw_out}), 24'(4 + b));
      end
      wr(7'h01, 8'h05);
      chk(24'({pll_low_noise_out, pll_bw_out}), 24'h000003);
      chk(24'(mode_out), 24'(tsm_pkg::TSM_RX));
      wr(7'h01, 8'h01);
      $display("Synthesizer selection done");
      wr(7'h02, 8'h00);
      wr(7'h03, 8'h10);
      wr(7'h5D, 8'h08);
      wr(7'h0B, 8'h29);
      tx_sync_mode_in = 1'b1;
      tx_bit_in = 1'b1;
      wr(7'h01, 8'h43);
      span(1'b1, 2, n);
      chk(24'(n), 24'h000021);
      takes(1'b1, 5);
      chk(synth_word_out, 24'hD92092);
      takes(1'b0, 2);
      chk(synth_word_out, 24'hD92040);
      takes(1'b0, 1);
      chk(synth_word_out, 24'hD91FEE);
      wr(7'h5D, 8'h00);
      span(1'b1, 2, n);
      chk(24'(n), 24'h000020);
      wr(7'h01, 8'h01);
      wr(7'h0B, 8'h49);
      wr(7'h01, 8'h43);
      takes(1'b1, 5);
      chk(synth_word_out, 24'hD92092);
      takes(1'b0, 3);
      chk(synth_word_out, 24'hD92040);
      takes(1'b0, 2);
      chk(synth_word_out, 24'hD91FEE);
      $display("Frequency shift keying done");
      wr(7'h01, 8'h01);
      tx_sync_mode_in = 1'b0;
      wr(7'h0B, 8'h29);
      wr(7'h01, 8'h63);
      tx_bit_in = 1'b1;
      wait_sig(1'b1, 1'b1);
      @(posedge link_clk);
      #1;
      b0 = pa_bias_out;
      @(posedge link_clk);
      #1;
      chk(24'(pa_bias_out - b0), 24'h000001);
      // A full ramp takes one link cycle per bias step
      repeat (70) @(posedge link_clk);
      chk(24'(pa_bias_out), 24'h00003F);
      wr(7'h01, 8'h01);
      wr(7'h0B, 8'h09);
      wr(7'h01, 8'h63);
      chk(24'({pa_on_out, pa_bias_out}), 24'h00007F);
      tx_bit_in = 1'b0;
      wait_sig(1'b1, 1'b0);
      repeat (2) @(posedge link_clk);
      chk(24'(pa_bias_out), 24'h000000);
      $display("On-off keying done");
      end_sim();
   end
endmodule : tsm_bench
